// [dv/vital_product_data_access_bench.sv]
// Self-checking bench for the vital product data access unit
`timescale 1ns/100ps
module vital_product_data_access_bench;
   import vpa_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   vpa_cfg_req_s pq = '0;
   vpa_cfg_req_s sq = '0;
   vpa_cfg_rsp_s pr, sr;
   vpa_rom_req_s rq;
   logic ack, busy;
   logic [7:0] rd;
   logic [2:0] lat = 3'h0;
   logic [7:0] sh [1024];
   logic [31:0] s = 32'h32, v, r0;
   int err_total = 0, n_checks = 0, cyc = 0;
   always #20 clk = ~clk;
   vpa_access dut (.i_ref_clk(clk), .i_reset(rst), .i_pri_req(pq), .o_pri_rsp(pr),
      .i_sec_req(sq), .o_sec_rsp(sr), .o_rom_req(rq), .i_rom_ack(ack), .i_rom_rdata(rd),
      .o_busy(busy));
   vpa_rom_model rom (.i_ref_clk(clk), .i_reset(rst), .i_req(rq), .i_lat(lat), .o_ack(ack),
      .o_rdata(rd));
   function automatic logic [31:0] xs();
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   task automatic chk(string n, logic [31:0] e, logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         err_total++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   // Address/control word; the low half is the fixed capability header
   function automatic logic [31:0] exp_ctrl(logic f, logic [8:0] a);
      return {f, 6'h00, a, 8'hEC, 8'h03};
   endfunction
   // Lowering valid one edge later keeps one assignment per time step
   task automatic acc(bit sd, bit w, logic [7:0] a, logic [3:0] be, logic [31:0] wd,
         output logic [31:0] r);
      if (sd) sq = '{1'b1, w, a, be, wd};
      else pq = '{1'b1, w, a, be, wd};
      @(posedge clk) #1;
      r = sd ? sr.rdata : pr.rdata;
      if (!w) chk("rsp", 1, sd ? sr.valid : pr.valid);
      pq.valid = 1'b0;
      sq.valid = 1'b0;
      @(posedge clk) #1;
   endtask
   task automatic op(bit sd, bit w, logic [8:0] a);
      logic [31:0] r, e;
      logic [9:0] b;
      int n;
      b = 10'h080 + {1'b0, a};
      e = xs();
      n = 0;
      if (w) acc(sd, 1, 8'hE8, 4'hF, e, r);
      acc(sd, 1, 8'hE4, 4'hF, {w, 6'h3F, a, 16'hFFFF}, r);
      acc(sd, 0, 8'hE4, 4'hF, 32'h0, r);
      chk("flag_busy", w, r[31]);
      // Restart attempt from the other side while busy must be ignored
      acc(!sd, 1, 8'hE4, 4'hF, {!w, 6'h00, ~a, 16'h0000}, r);
      while (busy === 1'b1 && n < 100) begin
         @(posedge clk) #1;
         n++;
      end
      acc(sd, 0, 8'hE4, 4'hF, 32'h0, r);
      chk("ctrl", exp_ctrl(!w, a), r);
      if (w) for (int i = 0; i < 4; i++) sh[b + i] = e[8 * i +: 8];
      else begin
         acc(sd, 0, 8'hE8, 4'hF, 32'h0, r);
         chk("data", {sh[b + 3], sh[b + 2], sh[b + 1], sh[b]}, r);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_total++;
         results();
      end
   end
   initial begin
      for (int i = 0; i < 1024; i++) sh[i] = 8'(i * 3 + 1);
      repeat (16) @(posedge clk);
      #1 rst = 1'b0;
      op(0, 1, 9'h17F);
      op(1, 0, 9'h17F);
      op(0, 1, 9'h003);
      op(1, 0, 9'h001);
      op(0, 0, 9'h000);
      // Both sides write the low address byte at once; primary is taken
      sq = '{1'b1, 1'b1, 8'hE4, 4'h4, 32'h0034_0000};
      acc(0, 1, 8'hE4, 4'h4, 32'h00AB_0000, r0);
      chk("no_start", 0, busy);
      acc(1, 0, 8'hE4, 4'hF, 32'h0, r0);
      chk("addr_lo", exp_ctrl(1'b1, 9'h0AB), r0);
      acc(1, 0, 8'hF0, 4'hF, 32'h0, r0);
      chk("unmapped", 0, r0);
      repeat (12) begin
         v = xs();
         lat = v[2:0];
         op(v[3], v[4], 9'(v[16:8] % 9'h180));
      end
      results();
   end
endmodule // vital_product_data_access_bench

// [dv/vpa_access_properties.sv]
// Port checker for the vital product data access unit
`timescale 1ns/100ps
module vpa_access_properties (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire vpa_pkg::vpa_cfg_req_s i_pri_req,
   input wire vpa_pkg::vpa_cfg_rsp_s o_pri_rsp,
   input wire vpa_pkg::vpa_cfg_req_s i_sec_req,
   input wire vpa_pkg::vpa_cfg_rsp_s o_sec_rsp,
   input wire vpa_pkg::vpa_rom_req_s o_rom_req,
   input wire logic i_rom_ack,
   input wire logic [7:0] i_rom_rdata,
   input wire logic o_busy
);
   import vpa_pkg::*;
   logic [2:0] acks_ff;
   logic [2:0] nxt_acks;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_reset);
   always_comb begin
      nxt_acks = acks_ff;
      if (!o_busy) nxt_acks = 3'h0;
      else if (o_rom_req.valid && i_rom_ack) nxt_acks = acks_ff + 3'h1;
   end
   always_ff @(posedge i_ref_clk) begin
      acks_ff <= i_reset ? 3'h0 : nxt_acks;
   end
   sequence s_ctrl_rd;
      i_pri_req.valid && !i_pri_req.write && i_pri_req.addr == 8'hE4;
   endsequence
   sequence s_start;
      i_pri_req.valid && i_pri_req.write && i_pri_req.addr == 8'hE4
         && i_pri_req.be[3:2] == 2'h3 && !o_busy;
   endsequence
   property p_rsp; i_pri_req.valid && !i_pri_req.write |=> o_pri_rsp.valid; endproperty
   a_rsp: assert property (p_rsp) else $error("read not answered");
   property p_hdr; s_ctrl_rd |=> o_pri_rsp.rdata[15:0] == 16'hEC03; endproperty
   a_hdr: assert property (p_hdr) else $error("header wrong");
   property p_resv; s_ctrl_rd |=> o_pri_rsp.rdata[30:25] == 6'h00; endproperty
   a_resv: assert property (p_resv) else $error("reserved bits set");
   property p_start;
      s_start |=> o_busy && o_rom_req.valid && o_rom_req.write == $past(i_pri_req.wdata[31])
         && o_rom_req.addr == 10'h080 + $past(i_pri_req.wdata[24:16]);
   endproperty
   a_start: assert property (p_start) else $error("start wrong");
   sequence s_ack_then_req;
      o_rom_req.valid && i_rom_ack ##1 o_rom_req.valid;
   endsequence
   property p_adv;
      s_ack_then_req |-> o_rom_req.addr == $past(o_rom_req.addr) + 10'h1;
   endproperty
   a_adv: assert property (p_adv) else $error("address not advanced");
   property p_hold;
      o_rom_req.valid && !i_rom_ack |=> o_rom_req.valid && $stable(o_rom_req.addr);
   endproperty
   a_hold: assert property (p_hold) else $error("request dropped");
   property p_four; $fell(o_busy) |-> acks_ff == 3'h4 && !o_rom_req.valid; endproperty
   a_four: assert property (p_four) else $error("not four bytes");
   property p_idle; !o_busy |-> !o_rom_req.valid; endproperty
   a_idle: assert property (p_idle) else $error("request while idle");
   property p_flag_hold;
      o_busy && i_pri_req.valid && !i_pri_req.write && i_pri_req.addr == 8'hE4
         |=> o_pri_rsp.rdata[31] == $past(o_rom_req.write);
   endproperty
   a_flag_hold: assert property (p_flag_hold) else $error("flag changed while busy");
endmodule // vpa_access_properties
bind vpa_access vpa_access_properties u_props (.i_ref_clk(i_ref_clk), .i_reset(i_reset),
   .i_pri_req(i_pri_req), .o_pri_rsp(o_pri_rsp), .i_sec_req(i_sec_req), .o_sec_rsp(o_sec_rsp),
   .o_rom_req(o_rom_req), .i_rom_ack(i_rom_ack), .i_rom_rdata(i_rom_rdata), .o_busy(o_busy));

// [dv/vpa_rom_model.sv]
// Serial ROM stand-in answering byte requests after a set wait
`timescale 1ns/100ps
module vpa_rom_model (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire vpa_pkg::vpa_rom_req_s i_req,
   input wire logic [2:0] i_lat,
   output logic o_ack,
   output logic [7:0] o_rdata
);
   import vpa_pkg::*;
   logic [7:0] mem [1024];
   logic [2:0] wait_ff;
   initial for (int i = 0; i < 1024; i++) mem[i] = 8'(i * 3 + 1);
   // Data line toggles off-ack so a stale byte never looks valid
   always @(posedge i_ref_clk) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_reset) begin
         wait_ff <= 3'h0;
         o_rdata <= 8'h00;
      end else if (i_req.valid && !o_ack) begin
         wait_ff <= (wait_ff == i_lat) ? 3'h0 : wait_ff + 3'h1;
         if (wait_ff == i_lat) begin
            o_ack <= 1'b1;
            o_rdata <= mem[i_req.addr];
            if (i_req.write) mem[i_req.addr] <= i_req.wdata;
         end
      end
   end
endmodule // vpa_rom_model

// [src/vpa_access.sv]
// Vital product data access unit: capability registers and ROM sequencer
// Contract
// - Header low byte reads capability id 03h
// - Header high byte reads next pointer ECh
// - Nine-bit read-write byte address field
// - ROM location is address plus base 080h
// - Address bits 14:9 read zero, ignore writes
// - Writing flag 0 starts four-byte read
// - Read completion sets flag to 1
// - Writing flag 1 starts four-byte write
// - Write completion clears flag to 0
// - Any start address, four consecutive bytes
// - Same offsets from primary and secondary sides
// - Data register holds 32-bit transfer data
// - Byte 0 maps to starting address
`timescale 1ns/100ps
module vpa_access (
   input wire logic i_ref_clk,
   input wire logic i_reset,
   input wire vpa_pkg::vpa_cfg_req_s i_pri_req,
   output vpa_pkg::vpa_cfg_rsp_s o_pri_rsp,
   input wire vpa_pkg::vpa_cfg_req_s i_sec_req,
   output vpa_pkg::vpa_cfg_rsp_s o_sec_rsp,
   output vpa_pkg::vpa_rom_req_s o_rom_req,
   input wire logic i_rom_ack,
   input wire logic [7:0] i_rom_rdata,
   output logic o_busy
);
   import vpa_pkg::*;

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   vpa_state_e state_ff, nxt_state;
   logic [VPA_ADDR_W-1:0] addr_ff, nxt_addr;
   logic flag_ff, nxt_flag;
   logic [31:0] data_ff, nxt_data;
   logic [1:0] idx_ff, nxt_idx;
   vpa_rom_req_s rom_ff, nxt_rom;
   vpa_cfg_rsp_s pri_rsp_ff, nxt_pri_rsp;
   vpa_cfg_rsp_s sec_rsp_ff, nxt_sec_rsp;
   logic busy_ff, nxt_busy;

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   // one decode shared by both sides
   function automatic logic [31:0] read_word(input logic [5:0] dw,
                                             input logic [VPA_ADDR_W-1:0] a,
                                             input logic f,
                                             input logic [31:0] d);
      logic [31:0] w;
      w = 32'h0000_0000;
      if (dw == VPA_DW_CTRL) begin
         w[7:0] = VPA_CAP_ID;
         w[15:8] = VPA_NEXT_PTR;
         w[16 +: VPA_ADDR_W] = a;
         w[16 + VPA_FLAG_BIT] = f;
      end else if (dw == VPA_DW_DATA) begin
         w = d;
      end
      return w;
   endfunction

   // byte-enabled update of the data word
   function automatic logic [31:0] merge_bytes(input logic [31:0] old,
                                               input logic [31:0] wd,
                                               input logic [3:0] be);
      logic [31:0] r;
      r = old;
      for (int i = 0; i < VPA_BYTE_LANES; i++) begin
         if (be[i]) begin
            r[8*i +: 8] = wd[8*i +: 8];
         end
      end
      return r;
   endfunction

   function automatic logic is_write(input vpa_cfg_req_s q, input logic [5:0] dw);
      return q.valid && q.write && (q.addr[7:2] == dw);
   endfunction

   // base plus byte address plus lane index
   function automatic logic [VPA_ROM_AW-1:0] rom_addr(input logic [VPA_ADDR_W-1:0] a,
                                                      input logic [1:0] i);
      return VPA_ROM_BASE + {1'b0, a} + {8'h00, i};
   endfunction

   // ---------------------------------------------------------------
   // Next-state logic
   // ---------------------------------------------------------------
   always_comb begin
      vpa_cfg_req_s wr;
      logic start;
      wr = i_sec_req;
      start = 1'b0;
      nxt_state = state_ff;
      nxt_addr = addr_ff;
      nxt_flag = flag_ff;
      nxt_data = data_ff;
      nxt_idx = idx_ff;
      nxt_rom = rom_ff;

      // Primary wins when both sides write in the same cycle
      if (i_pri_req.valid && i_pri_req.write) begin
         wr = i_pri_req;
      end

      unique case (state_ff)
         VPA_IDLE: begin
            if (is_write(wr, VPA_DW_DATA)) begin
               nxt_data = merge_bytes(data_ff, wr.wdata, wr.be);
            end
            if (is_write(wr, VPA_DW_CTRL)) begin
               if (wr.be[2]) begin
                  nxt_addr[7:0] = wr.wdata[23:16];
               end
               // Flag byte write launches the access
               if (wr.be[3]) begin
                  nxt_addr[VPA_ADDR_W-1] = wr.wdata[16 + VPA_ADDR_W - 1];
                  nxt_flag = wr.wdata[16 + VPA_FLAG_BIT];
                  start = 1'b1;
               end
            end
            if (start) begin
               // flag 0 is a read; flag 1 is a write
               nxt_state = VPA_XFER;
               nxt_idx = 2'h0;
               nxt_rom.valid = 1'b1;
               nxt_rom.write = nxt_flag;
               nxt_rom.addr = rom_addr(nxt_addr, 2'h0);
               nxt_rom.wdata = nxt_data[7:0];
            end
         end
         VPA_XFER: begin
            // register writes ignored, flag untouched while busy
            if (i_rom_ack) begin
               // lane index equals offset from start
               if (!rom_ff.write) begin
                  nxt_data[8*idx_ff +: 8] = i_rom_rdata;
               end
               if (idx_ff == VPA_LAST_BYTE) begin
                  nxt_state = VPA_IDLE;
                  nxt_rom.valid = 1'b0;
                  // read done sets flag; write done clears it
                  nxt_flag = !rom_ff.write;
               end else begin
                  nxt_idx = idx_ff + 2'h1;
                  nxt_rom.addr = rom_addr(addr_ff, idx_ff + 2'h1);
                  nxt_rom.wdata = data_ff[8*(idx_ff + 2'h1) +: 8];
               end
            end
         end
      endcase
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         state_ff <= VPA_IDLE;
         addr_ff <= VPA_ADDR_RST;
         flag_ff <= VPA_FLAG_RST;
         data_ff <= 32'h0000_0000;
         idx_ff <= 2'h0;
         rom_ff <= '0;
      end else begin
         state_ff <= nxt_state;
         addr_ff <= nxt_addr;
         flag_ff <= nxt_flag;
         data_ff <= nxt_data;
         idx_ff <= nxt_idx;
         rom_ff <= nxt_rom;
      end
   end

   // ---------------------------------------------------------------
   // Read answers
   // ---------------------------------------------------------------
   // both sides answer from the same registers, one cycle later
   always_comb begin
      nxt_pri_rsp.valid = i_pri_req.valid && !i_pri_req.write;
      nxt_pri_rsp.rdata = read_word(i_pri_req.addr[7:2], addr_ff, flag_ff, data_ff);
      nxt_sec_rsp.valid = i_sec_req.valid && !i_sec_req.write;
      nxt_sec_rsp.rdata = read_word(i_sec_req.addr[7:2], addr_ff, flag_ff, data_ff);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         pri_rsp_ff <= '0;
         sec_rsp_ff <= '0;
      end else begin
         pri_rsp_ff <= nxt_pri_rsp;
         sec_rsp_ff <= nxt_sec_rsp;
      end
   end

   // ---------------------------------------------------------------
   // Busy indication
   // ---------------------------------------------------------------
   // Follows the next state so busy and the flag settle on one edge
   always_comb begin
      nxt_busy = (nxt_state == VPA_XFER);
   end

   always_ff @(posedge i_ref_clk) begin
      if (i_reset) begin
         busy_ff <= 1'b0;
      end else begin
         busy_ff <= nxt_busy;
      end
   end

   assign o_pri_rsp = pri_rsp_ff;
   assign o_sec_rsp = sec_rsp_ff;
   assign o_rom_req = rom_ff;
   assign o_busy = busy_ff;
endmodule // vpa_access

// [src/vpa_pkg.sv]
// Package for the vital product data access unit: map, fields, types
package vpa_pkg;
   // ---------------------------------------------------------------
   // Register map (byte offsets in configuration space)
   // ---------------------------------------------------------------
   localparam logic [7:0] VPA_OFF_HEADER = 8'hE4;
   localparam logic [7:0] VPA_OFF_ADDR = 8'hE6;
   localparam logic [7:0] VPA_OFF_DATA = 8'hE8;
   localparam logic [5:0] VPA_DW_CTRL = VPA_OFF_HEADER[7:2];
   localparam logic [5:0] VPA_DW_DATA = VPA_OFF_DATA[7:2];

   // ---------------------------------------------------------------
   // Field values and positions
   // ---------------------------------------------------------------
   localparam logic [7:0] VPA_CAP_ID = 8'h03;
   localparam logic [7:0] VPA_NEXT_PTR = 8'hEC;
   localparam int VPA_ADDR_W = 9;
   localparam int VPA_FLAG_BIT = 15;
   localparam int VPA_ROM_AW = 10;
   localparam logic [VPA_ROM_AW-1:0] VPA_ROM_BASE = 10'h080;
   localparam logic [VPA_ADDR_W-1:0] VPA_ADDR_RST = 9'h000;
   localparam logic VPA_FLAG_RST = 1'b0;
   localparam logic [1:0] VPA_LAST_BYTE = 2'h3;
   localparam int VPA_BYTE_LANES = 4;

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic {VPA_IDLE, VPA_XFER} vpa_state_e;

   // One configuration access, single cycle
   typedef struct packed {
      logic valid;
      logic write;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } vpa_cfg_req_s;

   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
   } vpa_cfg_rsp_s;

   // One serial ROM byte request, held until acknowledged
   typedef struct packed {
      logic valid;
      logic write;
      logic [VPA_ROM_AW-1:0] addr;
      logic [7:0] wdata;
   } vpa_rom_req_s;
endpackage
